// [pkg/charge_setpoint_map.vh]
// Register offsets, field layouts, defaults and codes of the charge setpoint registers
// Function
// RULE1 - Boost limit bit: clear gives 0.5 A, set gives 1.2 A; defaults set.
// RULE2 - Full-on clear: high-resistance switch below 700 mA input limit; set: always low.
// RULE3 - In boost mode the full switch is always used; full-on bit ignored.
// RULE4 - Fast-charge field is six bits, 60 mA per step; zero disables charging.
// RULE5 - Fast-charge codes above 110010 act as 110010, i.e. 3000 mA.
// RULE6 - Precharge field four bits, 60 mA offset plus 60 mA steps; default 0010.
// RULE7 - Precharge settings above 780 mA act as code 1100.
// RULE8 - Termination field four bits, 60 mA offset, 60 mA steps; default 0010.
// RULE9 - Charge voltage field five bits, 3.856 V offset, 32 mV step, to 4.624 V.
// RULE10 - Charge voltage defaults to 01011; code 01111 selects 4.352 V specially.
// RULE11 - Charge voltage codes above 11000 act as 11000, i.e. 4.624 V.
// RULE12 - Top-off timer: 00 off (default), 01 15 min, 10 30 min, 11 45 min.
// RULE13 - With top-off off, charging ends as soon as termination is met.
// RULE14 - Register reset restores all fields; watchdog restores all but full-on bit.
// RULE15 - Recharge threshold bit defaults clear, giving 100 mV below charge voltage.
// RULE16 - Multi-byte access auto-increments addresses from register 0 to register 11.
// RULE17 - Undefined register address answers not-acknowledge and returns to idle.
`ifndef CHARGE_SETPOINT_MAP_VH
`define CHARGE_SETPOINT_MAP_VH
`define OFS_CHG_CUR       8'h02
`define OFS_PRE_TERM      8'h03
`define OFS_VOLT_TOPOFF   8'h04
`define OFS_LAST          8'h0B
`define RST_CHG_CUR       8'hA2
`define RST_PRE_TERM      8'h22
`define RST_VOLT_TOPOFF   8'h58
`define BIT_BOOST_CURRENT_LIMIT     7
`define BIT_FULL_ON       6
`define FCC_MSB           5
`define PRE_MSB           7
`define PRE_LSB           4
`define TERM_MSB          3
`define VOLT_MSB          7
`define VOLT_LSB          3
`define TOP_MSB           2
`define TOP_LSB           1
`define BIT_RECHG         0
`define FCC_MAX           6'h32
`define PRE_MAX           4'hC
`define VOLT_MAX          5'h18
`define VOLT_SPECIAL      5'h0F
`define VOLT_SPECIAL_MV   13'h1100
`define VOLT_BASE_MV      13'h0F10
`define CUR_STEP_MA       12'h03C
`define VOLT_STEP_MV      13'h0020
`define ILIM_LOW_MA       12'h2BC
`define ILIM_STEP_MA      12'h064
`define TOP_OFF           2'h0
`endif

// [src/setpoint_decode.v]
// Converts raw setpoint codes into clamped working values
`timescale 1ns/1ns
`default_nettype none
`include "charge_setpoint_map.vh"
module setpoint_decode
(
   input  wire [5:0]  fccCode,
   input  wire [3:0]  preCode,
   input  wire [3:0]  termCode,
   input  wire [4:0]  voltCode,
   output wire [5:0]  fccEff,
   output wire [3:0]  preEff,
   output wire [11:0] fccMa,
   output wire [11:0] preMa,
   output wire [11:0] termMa,
   output wire [12:0] voltMv,
   output wire        chargeOff
);
   // ****************************************
   // Clamps and scaling
   // ****************************************
   wire [4:0] voltEff;
   assign fccEff    = (fccCode > `FCC_MAX) ? `FCC_MAX : fccCode;        // see RULE5
   assign preEff    = (preCode > `PRE_MAX) ? `PRE_MAX : preCode;        // see RULE7
   assign voltEff   = (voltCode > `VOLT_MAX) ? `VOLT_MAX : voltCode;    // see RULE11
   assign fccMa     = {6'h00, fccEff} * `CUR_STEP_MA;                   // see RULE4
   assign chargeOff = (fccEff == 6'h00);                                // see RULE4
   assign preMa     = ({8'h00, preEff} + 12'h001) * `CUR_STEP_MA;       // see RULE6
   assign termMa    = ({8'h00, termCode} + 12'h001) * `CUR_STEP_MA;     // see RULE8
   assign voltMv    = (voltEff == `VOLT_SPECIAL) ? `VOLT_SPECIAL_MV :   // see RULE10
                      `VOLT_BASE_MV + {8'h00, voltEff} * `VOLT_STEP_MV; // see RULE9
endmodule // setpoint_decode
`default_nettype wire

// [src/charge_setpoint_registers.v]
// Charge setpoint register bank behind the serial register port
`timescale 1ns/1ns
`default_nettype none
`include "charge_setpoint_map.vh"
module charge_setpoint_registers
(
   input  wire        clk,
   input  wire        rst_n,
   input  wire        regReset,
   input  wire        watchdogExpire,
   input  wire        xferStart,
   input  wire        addrValid,
   input  wire [7:0]  addrIn,
   input  wire        wrValid,
   input  wire [7:0]  wrData,
   input  wire        rdReq,
   input  wire        xferStop,
   input  wire [4:0]  inputCurrentLimit,
   input  wire        boostMode,
   input  wire        termMet,
   output reg  [7:0]  rdData,
   output wire        addrAck,
   output wire        addrNack,
   output reg  [7:0]  curAddr,
   output reg         busy,
   output reg         boostCurrentLimit,
   output reg         useLowResSwitch,
   output reg  [11:0] fastChargeMa,
   output reg         chargeDisabled,
   output reg  [11:0] prechargeMa,
   output reg  [11:0] terminationMa,
   output reg  [12:0] chargeVoltageMv,
   output reg  [1:0]  topoffDuration,
   output reg         recharge200mV,
   output reg         endChargeNow
);
   // ****************************************
   // Storage and access pointer
   // ****************************************
   reg  [7:0]  chgCur_q;
   reg  [7:0]  preTerm_q;
   reg  [7:0]  voltTop_q;
   wire [5:0]  fccEff;
   wire [3:0]  preEff;
   wire [11:0] fccMa;
   wire [11:0] preMa;
   wire [11:0] termMa;
   wire [12:0] voltMv;
   wire        chargeOff;
   wire [11:0] ilimMa;
   wire [7:0]  chgCurDefault;

   // Default image of the current register, sliced on watchdog expiry
   assign chgCurDefault = `RST_CHG_CUR;

   // Address in the range the bank answers to
   function inRange;
      input [7:0] a;
      begin
         inRange = (a <= `OFS_LAST);
      end
   endfunction

   // Read mux; registers outside this bank read zero here
   function [7:0] readMux;
      input [7:0] a;
      input [7:0] r2;
      input [7:0] r3;
      input [7:0] r4;
      begin
         case (a)
            `OFS_CHG_CUR:     readMux = r2;
            `OFS_PRE_TERM:    readMux = r3;
            `OFS_VOLT_TOPOFF: readMux = r4;
            default:          readMux = 8'h00;
         endcase
      end
   endfunction

   assign addrAck  = addrValid & inRange(addrIn);
   assign addrNack = addrValid & ~inRange(addrIn);                      // see RULE17

   // ****************************************
   // Transfer pointer
   // ****************************************
   always @(posedge clk)
   begin
      if (!rst_n || xferStop || addrNack || (xferStart && !addrValid))  // see RULE17
      begin
         busy    <= 1'b0;
         curAddr <= 8'h00;
      end
      else if (addrAck)
      begin
         busy    <= 1'b1;
         curAddr <= addrIn;
      end
      else if (busy && (wrValid || rdReq) && curAddr < `OFS_LAST)
      begin
         curAddr <= curAddr + 8'h01;                                    // see RULE16
      end
   end

   always @(posedge clk)
   begin
      if (!rst_n)
         rdData <= 8'h00;
      else if (busy && rdReq)
         rdData <= readMux(curAddr, chgCur_q, preTerm_q, voltTop_q);    // see RULE16
   end

   // ****************************************
   // Registers with their reset sources
   // ****************************************
   always @(posedge clk)
   begin
      if (!rst_n || regReset)                                           // see RULE14
      begin
         chgCur_q  <= `RST_CHG_CUR;                                     // see RULE1
         preTerm_q <= `RST_PRE_TERM;                                    // see RULE6
         voltTop_q <= `RST_VOLT_TOPOFF;                                 // see RULE10
      end
      else if (watchdogExpire)
      begin
         chgCur_q  <= {chgCurDefault[`BIT_BOOST_CURRENT_LIMIT],                   // see RULE14
                       chgCur_q[`BIT_FULL_ON],
                       chgCurDefault[`FCC_MSB:0]};
         preTerm_q <= `RST_PRE_TERM;                                    // see RULE8
         voltTop_q <= `RST_VOLT_TOPOFF;                                 // see RULE15
      end
      else if (busy && wrValid)
      begin
         case (curAddr)
            `OFS_CHG_CUR:     chgCur_q  <= wrData;
            `OFS_PRE_TERM:    preTerm_q <= wrData;
            `OFS_VOLT_TOPOFF: voltTop_q <= wrData;
            default:          chgCur_q  <= chgCur_q;
         endcase
      end
   end

   // ****************************************
   // Decoded settings
   // ****************************************
   setpoint_decode uDecode
   (
      .fccCode   (chgCur_q[`FCC_MSB:0]),
      .preCode   (preTerm_q[`PRE_MSB:`PRE_LSB]),
      .termCode  (preTerm_q[`TERM_MSB:0]),
      .voltCode  (voltTop_q[`VOLT_MSB:`VOLT_LSB]),
      .fccEff    (fccEff),
      .preEff    (preEff),
      .fccMa     (fccMa),
      .preMa     (preMa),
      .termMa    (termMa),
      .voltMv    (voltMv),
      .chargeOff (chargeOff)
   );

   assign ilimMa = ({7'h00, inputCurrentLimit} + 12'h001) * `ILIM_STEP_MA;

   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         boostCurrentLimit <= 1'b1;
         useLowResSwitch   <= 1'b1;
         fastChargeMa      <= 12'h000;
         chargeDisabled    <= 1'b1;
         prechargeMa       <= 12'h000;
         terminationMa     <= 12'h000;
         chargeVoltageMv   <= 13'h0000;
         topoffDuration    <= 2'h0;
         recharge200mV     <= 1'b0;
         endChargeNow      <= 1'b0;
      end
      else
      begin
         boostCurrentLimit <= chgCur_q[`BIT_BOOST_CURRENT_LIMIT];                 // see RULE1
         useLowResSwitch   <= boostMode ||                              // see RULE3
                              chgCur_q[`BIT_FULL_ON] ||                 // see RULE2
                              (ilimMa >= `ILIM_LOW_MA);
         fastChargeMa      <= fccMa;                                    // see RULE5
         chargeDisabled    <= chargeOff;                                // see RULE4
         prechargeMa       <= preMa;                                    // see RULE7
         terminationMa     <= termMa;                                   // see RULE8
         chargeVoltageMv   <= voltMv;                                   // see RULE9
         topoffDuration    <= voltTop_q[`TOP_MSB:`TOP_LSB];             // see RULE12
         recharge200mV     <= voltTop_q[`BIT_RECHG];                    // see RULE15
         endChargeNow      <= termMet &&                                // see RULE13
                              (voltTop_q[`TOP_MSB:`TOP_LSB] == `TOP_OFF);
      end
   end
endmodule // charge_setpoint_registers
`default_nettype wire

// [tb/charge_setpoint_registers_chk.sv]
// Port checker for the charge setpoint register bank
`timescale 1ns/1ns
`default_nettype none
module charge_setpoint_registers_chk
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        addrValid,
   input wire logic [7:0]  addrIn,
   input wire logic        wrValid,
   input wire logic        rdReq,
   input wire logic        addrNack,
   input wire logic        busy,
   input wire logic [7:0]  curAddr,
   input wire logic        boostMode,
   input wire logic        useLowResSwitch,
   input wire logic        chargeDisabled,
   input wire logic [11:0] fastChargeMa,
   input wire logic [11:0] prechargeMa,
   input wire logic [12:0] chargeVoltageMv
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_addr_nack: assert property (addrValid && addrIn > 8'h0B |-> addrNack)
      else $error("Bad address not refused");
   chk_nack_idle: assert property (addrValid && addrNack |=> !busy)
      else $error("Busy after refusal");
   chk_ptr_step: assert property (busy && (wrValid || rdReq) && curAddr < 8'h0B
      |=> curAddr == $past(curAddr) + 8'h01) else $error("Pointer did not step");
   chk_boost_full: assert property ($past(boostMode) && $past(boostMode, 2)
      |-> useLowResSwitch) else $error("Boost without full switch");
   chk_fcc_clamp: assert property (fastChargeMa <= 12'hBB8
      && fastChargeMa % 12'h03C == 12'h000) else $error("Fast charge out of range");
   chk_off_zero: assert property (chargeDisabled == (fastChargeMa == 12'h000))
      else $error("Charge off flag wrong");
   chk_volt_range: assert property ($past(rst_n) |-> chargeVoltageMv >= 13'h0F10
      && chargeVoltageMv <= 13'h1210) else $error("Charge voltage out of range");
   chk_pre_clamp: assert property ($past(rst_n) |-> prechargeMa >= 12'h03C
      && prechargeMa <= 12'h30C) else $error("Precharge out of range");
   cover property (addrValid && addrNack);
   cover property (chargeVoltageMv == 13'h1100);
   cover property (busy && wrValid && curAddr == 8'h04);
endmodule // charge_setpoint_registers_chk
bind charge_setpoint_registers charge_setpoint_registers_chk u_charge_setpoint_registers_chk (
   .clk, .rst_n, .addrValid, .addrIn, .wrValid, .rdReq, .addrNack, .busy, .curAddr,
   .boostMode, .useLowResSwitch, .chargeDisabled, .fastChargeMa, .prechargeMa,
   .chargeVoltageMv);
`default_nettype wire

// [tb/reg_host_model.sv]
// Host model issuing register port requests
`timescale 1ns/1ns
`default_nettype none
module reg_host_model
(
   input  wire logic       clk,
   input  wire logic       addrAck,
   output var  logic       addrValid,
   output var  logic [7:0] addrIn,
   output var  logic       wrValid,
   output var  logic [7:0] wrData,
   output var  logic       rdReq,
   output var  logic       xferStop,
   output var  logic       ackSeen
);
   initial
   begin
      {addrValid, wrValid, rdReq, xferStop, ackSeen} = 5'h00;
      addrIn = 8'h00;
      wrData = 8'h00;
   end
   // Kind 0 address, 1 write, 2 read, 3 stop; data lines inverted once released
   task automatic pulse(input int kind, input logic [7:0] v);
      @(posedge clk);
      addrValid <= kind == 0;
      wrValid <= kind == 1;
      rdReq <= kind == 2;
      xferStop <= kind == 3;
      addrIn <= v;
      wrData <= v;
      @(posedge clk);
      if (kind == 0) ackSeen <= addrAck;
      {addrValid, wrValid, rdReq, xferStop} <= 4'h0;
      addrIn <= ~v;
      wrData <= ~v;
   endtask
endmodule // reg_host_model
`default_nettype wire

// [tb/charge_setpoint_registers_tb.sv]
// Self-checking testbench for the charge setpoint register bank
`timescale 1ns/1ns
`default_nettype none
module charge_setpoint_registers_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        regReset = 1'b0;
   logic        watchdogExpire = 1'b0;
   logic [4:0]  inputCurrentLimit = 5'h00;
   logic        boostMode = 1'b0;
   logic        termMet = 1'b0;
   logic        addrValid, wrValid, rdReq, xferStop, addrAck, addrNack, busy, ackSeen;
   logic [7:0]  addrIn, wrData, rdData, curAddr;
   logic        boostCurrentLimit, useLowResSwitch, chargeDisabled, recharge200mV, endChargeNow;
   logic [11:0] fastChargeMa, prechargeMa, terminationMa;
   logic [12:0] chargeVoltageMv;
   logic [1:0]  topoffDuration;
   logic [7:0]  r [2:4];
   integer      seed = 32'h3d9c;
   int          mismatches = 0;
   int          testsRun = 0;
   always #50 clk = ~clk;
   charge_setpoint_registers u_charge_setpoint_registers (.clk, .rst_n, .regReset,
      .watchdogExpire, .xferStart(1'b0), .addrValid, .addrIn, .wrValid, .wrData, .rdReq,
      .xferStop, .inputCurrentLimit, .boostMode, .termMet, .rdData, .addrAck, .addrNack,
      .curAddr, .busy, .boostCurrentLimit, .useLowResSwitch, .fastChargeMa, .chargeDisabled,
      .prechargeMa, .terminationMa, .chargeVoltageMv, .topoffDuration, .recharge200mV,
      .endChargeNow);
   reg_host_model u_reg_host_model (.clk, .addrAck, .addrValid, .addrIn, .wrValid, .wrData,
      .rdReq, .xferStop, .ackSeen);
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] regAt(input int a);
      return (a >= 2 && a <= 4) ? r[a] : 8'h00;
   endfunction
   // Multi-byte transfer from address a; reads are compared with the model
   task automatic xfer(input int a, input int n, input logic wr);
      u_reg_host_model.pulse(0, 8'(a));
      #1 cmp(ackSeen, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         u_reg_host_model.pulse(wr ? 1 : 2, regAt(a + i));
         #1 if (!wr) cmp(rdData, regAt(a + i));
      end
      u_reg_host_model.pulse(3, 8'h00);
   endtask
   task automatic checkOut;
      logic [5:0] f;
      logic [3:0] p;
      logic [4:0] v;
      f = r[2][5:0] > 6'h32 ? 6'h32 : r[2][5:0];
      p = r[3][7:4] > 4'hC ? 4'hC : r[3][7:4];
      v = r[4][7:3] > 5'h18 ? 5'h18 : r[4][7:3];
      repeat (3) @(posedge clk);
      #1 cmp(boostCurrentLimit, r[2][7]);
      cmp(useLowResSwitch, r[2][6] | boostMode | (inputCurrentLimit >= 5'h06));
      cmp(fastChargeMa, f * 12'h03C);
      cmp(chargeDisabled, f == 6'h00);
      cmp(prechargeMa, (p + 12'h001) * 12'h03C);
      cmp(terminationMa, (r[3][3:0] + 12'h001) * 12'h03C);
      cmp(chargeVoltageMv, v == 5'h0F ? 13'h1100 : 13'h0F10 + v * 13'h0020);
      cmp({topoffDuration, recharge200mV}, r[4][2:0]);
      cmp(endChargeNow, termMet && r[4][2:1] == 2'h0);
   endtask
   task automatic kick(input logic wd);
      @(posedge clk);
      watchdogExpire <= wd;
      regReset <= !wd;
      @(posedge clk);
      {watchdogExpire, regReset} <= 2'h0;
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      r[2] = 8'hA2;
      r[3] = 8'h22;
      r[4] = 8'h58;
      checkOut();
      xfer(0, 6, 1'b0);
      $display("Reset values test done");
      for (int i = 0; i < 24; i++)
      begin
         @(posedge clk);
         inputCurrentLimit <= 5'($random(seed));
         boostMode <= 1'($random(seed));
         termMet <= 1'($random(seed));
         r[2] = i == 0 ? 8'hFF : i == 1 ? 8'h00 : i == 2 ? 8'h72 : 8'($random(seed));
         r[3] = i == 0 ? 8'hFF : i == 2 ? 8'hC0 : 8'($random(seed));
         r[4] = i == 0 ? 8'hFF : i == 1 ? 8'h78 : i == 2 ? 8'hC6 : 8'($random(seed));
         xfer(2, 3, 1'b1);
         checkOut();
         xfer(2, 3, 1'b0);
      end
      $display("Random setpoint test done");
      u_reg_host_model.pulse(0, 8'h02);
      u_reg_host_model.pulse(0, 8'h0C);
      #1 cmp({ackSeen, busy}, 2'h0);
      u_reg_host_model.pulse(1, 8'h00);
      r[2] = 8'h7F;
      xfer(2, 1, 1'b1);
      kick(1'b1);
      r[2] = 8'hE2;
      r[3] = 8'h22;
      r[4] = 8'h58;
      xfer(2, 3, 1'b0);
      kick(1'b0);
      r[2] = 8'hA2;
      xfer(2, 3, 1'b0);
      checkOut();
      $display("Refusal and reset test done");
      test_done();
   end
   initial
   begin
      #2000000;
      mismatches++;
      test_done();
   end
endmodule // charge_setpoint_registers_tb
`default_nettype wire
